//--- include/fault_status_pkg.sv
package fault_status_pkg;

  // Command codes that select a status register.
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_OUT_VOLT = 8'h7a;

  // Reset values.
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic [7:0] OUT_VOLTAGE_SUMMARY_RESET = 8'h00;

  // Summary bit positions.
  localparam int SB_BUSY = 7;
  localparam int SB_OFF = 6;
  localparam int SB_OV = 5;
  localparam int SB_OC = 4;
  localparam int SB_INUV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_COMM = 1;
  localparam int SW_OUT_VOLTAGE_SUMMARY = 15;
  localparam int SW_OUT_CURRENT_SUMMARY = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_VENDOR = 12;
  localparam int SW_PGOOD_N = 11;
  localparam int SW_OTHER = 9;

  // Output-voltage status bit positions.
  localparam int VB_OV_FAULT = 7;
  localparam int VB_UV_WARN = 5;
  localparam int VB_UV_FAULT = 4;

  // Position of the high byte inside the summary word.
  localparam int SW_HIGH_LSB = 8;

  // Positions that carry no meaning and always read zero.
  localparam logic [15:0] SUMMARY_UNUSED = 16'h0501;
  localparam logic [7:0] OUT_VOLTAGE_SUMMARY_UNUSED = 8'h4f;

  // Number of detail status registers feeding the summary.
  localparam int DETAIL_COUNT = 6;

  // Answer lengths in bytes.
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_NONE = 2'h0;

endpackage

//--- design/status_capture.sv
`timescale 1ns/1ps
// One status bit register: follows its cause, clears to zero on reset.
module status_capture
  import fault_status_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_cause,
  output logic [WIDTH-1:0] o_bits
);

  logic [WIDTH-1:0] bits_d;

  // Next value is the present cause; the register only samples it.
  always_comb begin
    bits_d = i_cause;
  end

  // Held still while the clock enable is low.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_bits <= '0;
    end else if (i_ce) begin
      o_bits <= bits_d;
    end
  end

endmodule

//--- design/power_fault_status_summary.sv
`timescale 1ns/1ps
module power_fault_status_summary
  import fault_status_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_busy_fault,
  input wire logic i_output_off,
  input wire logic i_out_overvolt_fault,
  input wire logic i_out_overcurrent_fault,
  input wire logic i_in_undervolt_fault,
  input wire logic i_temperature_flag,
  input wire logic i_comm_mem_logic_flag,
  input wire logic i_out_undervolt_warning,
  input wire logic i_out_undervolt_fault,
  input wire logic i_out_current_summary,
  input wire logic i_input_summary,
  input wire logic i_vendor_specific_summary,
  input wire logic i_power_good,
  input wire logic [DETAIL_COUNT-2:0] i_other_detail_nonzero,
  input wire logic i_rd_req,
  input wire logic [7:0] i_rd_cmd,
  output logic o_rd_valid,
  output logic [1:0] o_rd_len,
  output logic [15:0] o_rd_data,
  output logic [7:0] o_summary_byte,
  output logic [15:0] o_summary_word,
  output logic [7:0] o_out_volt_status
);

  logic [7:0] low_cause;
  logic [7:0] high_cause;
  logic [7:0] out_voltage_summary_cause;
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [7:0] out_voltage_summary_q;
  logic detail_any;
  logic rd_valid_q;
  logic rd_valid_d;
  logic [1:0] rd_len_q;
  logic [1:0] rd_len_d;
  logic [15:0] rd_data_q;
  logic [15:0] rd_data_d;

  // Output-voltage status byte; bits 6 and 3 to 0 are left unused on purpose.
  always_comb begin
    out_voltage_summary_cause = OUT_VOLTAGE_SUMMARY_RESET;
    out_voltage_summary_cause[VB_OV_FAULT] = i_out_overvolt_fault;
    out_voltage_summary_cause[VB_UV_WARN] = i_out_undervolt_warning;
    out_voltage_summary_cause[VB_UV_FAULT] = i_out_undervolt_fault;
  end

  // Any detail register nonzero; voltage detail uses our own byte.
  assign detail_any = (|out_voltage_summary_cause) || (|i_other_detail_nonzero);

  // Low summary byte causes; bit 0 stays zero.
  always_comb begin
    low_cause = SUMMARY_RESET[7:0];
    low_cause[SB_BUSY] = i_busy_fault;
    low_cause[SB_OFF] = i_output_off;
    low_cause[SB_OV] = i_out_overvolt_fault;
    low_cause[SB_OC] = i_out_overcurrent_fault;
    low_cause[SB_INUV] = i_in_undervolt_fault;
    low_cause[SB_TEMP] = i_temperature_flag;
    low_cause[SB_COMM] = i_comm_mem_logic_flag;
  end

  // High summary byte causes; bits 10 and 8 stay zero.
  always_comb begin
    high_cause = SUMMARY_RESET[15:8];
    high_cause[SW_OUT_VOLTAGE_SUMMARY-SW_HIGH_LSB] = |out_voltage_summary_cause;
    high_cause[SW_OUT_CURRENT_SUMMARY-SW_HIGH_LSB] = i_out_current_summary;
    high_cause[SW_INPUT-SW_HIGH_LSB] = i_input_summary;
    high_cause[SW_VENDOR-SW_HIGH_LSB] = i_vendor_specific_summary;
    high_cause[SW_PGOOD_N-SW_HIGH_LSB] = !i_power_good;
    high_cause[SW_OTHER-SW_HIGH_LSB] = detail_any;
  end

  // A single low-byte register serves both summary commands.
  status_capture #(.WIDTH(8)) u_low (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_cause(low_cause),
    .o_bits(low_q)
  );

  status_capture #(.WIDTH(8)) u_high (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_cause(high_cause),
    .o_bits(high_q)
  );

  status_capture #(.WIDTH(8)) u_out_voltage_summary (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_cause(out_voltage_summary_cause),
    .o_bits(out_voltage_summary_q)
  );

  // Read decode. No write path exists, so protection cannot apply.
  // Unknown commands answer with a zero length so the bus can refuse them.
  always_comb begin
    rd_valid_d = 1'b0;
    rd_len_d = LEN_NONE;
    rd_data_d = SUMMARY_RESET;
    if (i_rd_req) begin
      rd_valid_d = 1'b1;
      case (i_rd_cmd)
        CMD_SUMMARY_BYTE: begin
          rd_len_d = LEN_ONE;
          rd_data_d = {8'h00, low_q};
        end
        CMD_SUMMARY_WORD: begin
          rd_len_d = LEN_TWO;
          rd_data_d = {high_q, low_q};
        end
        CMD_OUT_VOLT: begin
          rd_len_d = LEN_ONE;
          rd_data_d = {8'h00, out_voltage_summary_q};
        end
        default: begin
          rd_len_d = LEN_NONE;
        end
      endcase
    end
  end

  // Answer registers; outputs come straight from flops.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rd_valid_q <= 1'b0;
      rd_len_q <= LEN_NONE;
      rd_data_q <= SUMMARY_RESET;
    end else if (i_ce) begin
      rd_valid_q <= rd_valid_d;
      rd_len_q <= rd_len_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign o_rd_valid = rd_valid_q;
  assign o_rd_len = rd_len_q;
  assign o_rd_data = rd_data_q;
  assign o_summary_byte = low_q;
  assign o_summary_word = {high_q, low_q};
  assign o_out_volt_status = out_voltage_summary_q;

  // Word low byte and the byte read are the same storage.
  summary_alias_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_summary_word[7:0] == o_summary_byte)
    else $error("low byte mismatch");

  // Looked at one edge after reset, once the flops have taken their reset edge.
  reset_zero_a: assert property (@(posedge i_mclk)
    $past(i_srst) |->
    (o_summary_word == SUMMARY_RESET && o_out_volt_status == OUT_VOLTAGE_SUMMARY_RESET && !o_rd_valid))
    else $error("status not zero after reset");

  // Read answers carry the registers as they stood at the request edge.
  byte_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_rd_req && i_rd_cmd == CMD_SUMMARY_BYTE) |=>
    (o_rd_valid && o_rd_len == LEN_ONE && o_rd_data == {8'h00, $past(low_q)}))
    else $error("byte read wrong");

  word_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_rd_req && i_rd_cmd == CMD_SUMMARY_WORD) |=>
    (o_rd_valid && o_rd_len == LEN_TWO && o_rd_data == $past({high_q, low_q})))
    else $error("word read wrong");

  out_voltage_summary_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_rd_req && i_rd_cmd == CMD_OUT_VOLT) |=>
    (o_rd_valid && o_rd_len == LEN_ONE && o_rd_data == {8'h00, $past(out_voltage_summary_q)}))
    else $error("voltage read wrong");

  // Codes outside the three status commands are answered with a zero length.
  unknown_code_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_rd_req && i_rd_cmd != CMD_SUMMARY_BYTE && i_rd_cmd != CMD_SUMMARY_WORD &&
     i_rd_cmd != CMD_OUT_VOLT) |=>
    (o_rd_valid && o_rd_len == LEN_NONE && o_rd_data == SUMMARY_RESET))
    else $error("unknown code answered");

  // Without a request the answer strobe drops, so one request gives one pulse.
  valid_pulse_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !i_rd_req) |=> !o_rd_valid)
    else $error("answer strobe without request");

  // Each low summary bit follows its own cause one enabled edge later.
  // They are live levels, so a cause that goes away clears its bit at the next edge.
  busy_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_byte[SB_BUSY] == $past(i_busy_fault))
    else $error("busy bit wrong");

  off_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_byte[SB_OFF] == $past(i_output_off))
    else $error("off bit wrong");

  overcurrent_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_byte[SB_OC] == $past(i_out_overcurrent_fault))
    else $error("overcurrent bit wrong");

  input_uv_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_byte[SB_INUV] == $past(i_in_undervolt_fault))
    else $error("input undervoltage bit wrong");

  temp_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_byte[SB_TEMP] == $past(i_temperature_flag))
    else $error("temperature bit wrong");

  comm_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_byte[SB_COMM] == $past(i_comm_mem_logic_flag))
    else $error("communication bit wrong");

  // High summary bits are fed by the wider detail summaries, except bit 11, which is the inverted power-good input.
  volt_summary_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_word[SW_OUT_VOLTAGE_SUMMARY] ==
    ($past(i_out_overvolt_fault) || $past(i_out_undervolt_warning) ||
     $past(i_out_undervolt_fault)))
    else $error("voltage summary bit wrong");

  current_summary_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_word[SW_OUT_CURRENT_SUMMARY] == $past(i_out_current_summary))
    else $error("current summary bit wrong");

  input_summary_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_word[SW_INPUT] == $past(i_input_summary))
    else $error("input summary bit wrong");

  vendor_summary_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_word[SW_VENDOR] == $past(i_vendor_specific_summary))
    else $error("vendor summary bit wrong");

  pgood_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_summary_word[SW_PGOOD_N] == !$past(i_power_good))
    else $error("power good bit wrong");

  other_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && (|i_other_detail_nonzero)) |=> o_summary_word[SW_OTHER])
    else $error("other bit not set");

  // Bit 9 must also drop once every detail register is clear again.
  other_clear_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !(|i_other_detail_nonzero) && !i_out_overvolt_fault &&
     !i_out_undervolt_warning && !i_out_undervolt_fault) |=> !o_summary_word[SW_OTHER])
    else $error("other bit stuck");

  // Output-voltage status bits and the summary bits that share their causes.
  out_voltage_summary_ov_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_out_overvolt_fault) |=>
    (o_out_volt_status[VB_OV_FAULT] && o_summary_byte[SB_OV] && o_summary_word[SW_OUT_VOLTAGE_SUMMARY]))
    else $error("overvoltage not flagged");

  ov_clear_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !i_out_overvolt_fault) |=>
    (!o_out_volt_status[VB_OV_FAULT] && !o_summary_byte[SB_OV]))
    else $error("overvoltage bit stuck");

  uv_warn_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_out_volt_status[VB_UV_WARN] == $past(i_out_undervolt_warning))
    else $error("undervoltage warning bit wrong");

  uv_fault_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_out_volt_status[VB_UV_FAULT] == $past(i_out_undervolt_fault))
    else $error("undervoltage fault bit wrong");

  // Unused positions must never show a one once the flops hold known values.
  unused_zero_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    ((o_summary_word & SUMMARY_UNUSED) == SUMMARY_RESET &&
     (o_out_volt_status & OUT_VOLTAGE_SUMMARY_UNUSED) == OUT_VOLTAGE_SUMMARY_RESET))
    else $error("unused bit set");

  // A low clock enable freezes every register, answers included.
  // A pending answer strobe therefore stays up until the enable returns.
  ce_freeze_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !i_ce |=> ($stable(o_summary_word) && $stable(o_out_volt_status) &&
     $stable(o_rd_valid) && $stable(o_rd_data)))
    else $error("state moved while enable low");

endmodule

//--- tb/host_reader.sv
`timescale 1ns/1ps
// Host side of the status read port: one request per transfer.
module host_reader (
  input wire logic i_mclk,
  input wire logic i_valid,
  input wire logic [1:0] i_len,
  input wire logic [15:0] i_data,
  output logic o_req,
  output logic [7:0] o_cmd
);
  initial begin
    o_req = 1'b0;
    o_cmd = 8'h5a;
  end

  // The code is scrambled once released, so a stale code can never pass for a fresh one.
  task automatic do_read(input logic [7:0] cmd, output logic [1:0] len,
                         output logic [15:0] data, output bit ok);
    ok = 1'b0;
    len = 2'h3;
    data = 16'hffff;
    @(posedge i_mclk);
    #1;
    o_req = 1'b1;
    o_cmd = cmd;
    @(posedge i_mclk);
    #1;
    o_req = 1'b0;
    o_cmd = ~cmd;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (i_valid === 1'b1) begin
        len = i_len;
        data = i_data;
        ok = 1'b1;
      end else begin
        @(posedge i_mclk);
        #1;
      end
    end
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb;
  import fault_status_pkg::*;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic clk_en = 1'b1;
  logic [12:0] c = '0;
  logic [4:0] d = '0;
  logic rd_req, rd_valid;
  logic [7:0] rd_cmd, o_summary_byte, o_out_volt_status;
  logic [1:0] rd_len;
  logic [15:0] rd_data, o_summary_word;
  int fail_count = 0;
  int checks_done = 0;

  // Half period of a 25 ns clock.
  always #12.5 i_mclk = ~i_mclk;

  power_fault_status_summary power_fault_status_summary_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(clk_en),
    .i_busy_fault(c[0]), .i_output_off(c[1]), .i_out_overvolt_fault(c[2]),
    .i_out_overcurrent_fault(c[3]), .i_in_undervolt_fault(c[4]),
    .i_temperature_flag(c[5]), .i_comm_mem_logic_flag(c[6]),
    .i_out_undervolt_warning(c[7]), .i_out_undervolt_fault(c[8]),
    .i_out_current_summary(c[9]), .i_input_summary(c[10]),
    .i_vendor_specific_summary(c[11]), .i_power_good(~c[12]),
    .i_other_detail_nonzero(d), .i_rd_req(rd_req), .i_rd_cmd(rd_cmd),
    .o_rd_valid(rd_valid), .o_rd_len(rd_len), .o_rd_data(rd_data),
    .o_summary_byte(o_summary_byte), .o_summary_word(o_summary_word),
    .o_out_volt_status(o_out_volt_status));

  host_reader host_reader_inst (
    .i_mclk(i_mclk), .i_valid(rd_valid), .i_len(rd_len), .i_data(rd_data),
    .o_req(rd_req), .o_cmd(rd_cmd));

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // One read through the host model; a lost answer ends the run at once.
  task automatic rd(input logic [7:0] cmd, input logic [17:0] want);
    logic [1:0] len;
    logic [15:0] dat;
    bit ok;
    host_reader_inst.do_read(cmd, len, dat, ok);
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t no answer", $time);
      wrap_up();
    end else begin
      `CHK({len, dat}, want)
    end
  endtask

  // Compares every register and all three reads with the value built from the causes.
  task automatic check_all();
    logic [7:0] v;
    logic [15:0] w;
    v = {c[2], 1'b0, c[7], c[8], 4'h0};
    w = {|v, c[9], c[10], c[11], c[12], 1'b0, (|d) | (|v), 1'b0,
         c[0], c[1], c[2], c[3], c[4], c[5], c[6], 1'b0};
    `CHK(o_summary_word, w)
    `CHK(o_summary_byte, w[7:0])
    `CHK(o_out_volt_status, v)
    rd(CMD_SUMMARY_WORD, {LEN_TWO, w});
    rd(CMD_SUMMARY_BYTE, {LEN_ONE, 8'h00, w[7:0]});
    rd(CMD_OUT_VOLT, {LEN_ONE, 8'h00, v});
  endtask

  // Each cause alone, so a swapped or missing bit shows by itself.
  task automatic t_single_causes();
    for (int i = 0; i < 18; i++) begin
      c = (i < 13) ? 13'h0001 << i : 13'h0000;
      d = (i < 13) ? 5'h00 : 5'h01 << (i - 13);
      step(2);
      check_all();
    end
  endtask

  task automatic t_unknown_code();
    rd(8'h7b, {LEN_NONE, 16'h0000});
    rd(8'h77, {LEN_NONE, 16'h0000});
  endtask

  // A low clock enable holds every register although the causes move underneath.
  task automatic t_ce_freeze();
    c = 13'h0004;
    d = '0;
    step(2);
    check_all();
    clk_en = 1'b0;
    c = 13'h1000;
    d = 5'h01;
    step(3);
    `CHK({o_summary_word, o_summary_byte, o_out_volt_status}, 32'h8220_2080)
    clk_en = 1'b1;
    step(2);
    check_all();
  endtask

  // Reset in mid-run with every cause raised must still clear everything.
  task automatic t_mid_reset();
    c = '1;
    d = '1;
    step(2);
    check_all();
    i_srst = 1'b1;
    step(2);
    `CHK({o_summary_word, o_summary_byte, o_out_volt_status}, 32'h0000_0000)
    i_srst = 1'b0;
    c = '0;
    d = '0;
    step(2);
    check_all();
  endtask

  initial begin
    step(5);
    i_srst = 1'b0;
    check_all();
    t_single_causes();
    t_unknown_code();
    t_ce_freeze();
    t_mid_reset();
    wrap_up();
  end
endmodule
